// ==== scr_pkg.sv ====
// Operation
// R1: internal mode captures one point per step interval, 1 to 100000 ms.
// R2: length is 1 to 16384 points; run ends or wraps on reaching it.
// R3: single mode stops at once when length drops below captured count.
// R4: loop mode restarts at first location when length drops below count.
// R5: eight stores of 16384 x 32 bits; four serve as capture targets.
// R6: each capture store records one selected source per point.
// R7: source selection takes effect only when a run restarts.
// R8: trigger mode selects step timer or external pulse input.
// R9: external mode captures one point into all four capture stores per pulse.
// R10: external pulses must not exceed 500 Hz.
// R11: start, pause and reset commands work in every mode.
// R12: single mode stops by itself after one full run.
// R13: loop mode wraps to first location and overwrites older points.
// R14: point index reads zero while capture sits in reset state.
// R15: reset clears count to idle; pause holds count, start resumes.
// R16: pulses while idle, paused or stopped never advance the count.
package scr_pkg;
  localparam int DW = 32;
  localparam int PAW = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STEP = 8'h04;
  localparam logic [7:0] A_LEN = 8'h08;
  localparam logic [7:0] A_SEL = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_RADDR = 8'h14;
  localparam logic [7:0] A_RDATA = 8'h18;
  localparam int CTL_EXT = 0;
  localparam int CTL_LOOP = 1;
  localparam int CTL_START = 4;
  localparam int CTL_PAUSE = 5;
  localparam int CTL_RESET = 6;
  localparam int STAT_ST_LSB = 0;
  localparam int STAT_BUSY = 4;
  localparam int STAT_PT_LSB = 16;
  localparam int ST_W = 4;
  localparam int STEP_W = 17;
  localparam logic [16:0] STEP_MIN_MS = 17'h00001;
  localparam logic [16:0] STEP_MAX_MS = 17'h186a0;
  localparam logic [16:0] STEP_RST = 17'h00001;
  localparam int LEN_W = 15;
  localparam logic [14:0] LEN_MIN = 15'h0001;
  localparam logic [14:0] LEN_MAX = 15'h4000;
  localparam int BUF_N = 8;
  localparam int ASSIGN_N = 4;
  localparam int BUF_AW = 14;
  localparam int BIDX_W = 3;
  localparam int MEM_AW = BIDX_W + BUF_AW;
  localparam int SEL_FW = 4;
  localparam int SRC_N = 7;
  localparam logic [15:0] SEL_RST = 16'h3210;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = MEM_AW + DW;
  localparam int STEP_UNIT_NS = 1000000;
  localparam int PCLK_NS = 5;
  localparam int SCR_CYC_PER_MS = STEP_UNIT_NS / PCLK_NS;
  typedef enum logic [3:0] {
    SRC_MAG = 4'h0, SRC_INPH = 4'h1, SRC_QUAD = 4'h2, SRC_PHASE = 4'h3,
    SRC_AUX3 = 4'h4, SRC_AUX4 = 4'h5, SRC_FREQ = 4'h6
  } scr_src_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_RUN = 4'h2, ST_PAUSE = 4'h4, ST_DONE = 4'h8
  } scr_state_t;
  function automatic logic [31:0] scr_clamp(input logic [31:0] v, input logic [31:0] lo,
                                            input logic [31:0] hi);
    scr_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
endpackage

// ==== scr_stream_if.sv ====
`timescale 1ns/1ps
interface scr_stream_if #(parameter int W = 1);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// ==== scr_store_mem.sv ====
`timescale 1ns/1ps
module scr_store_mem
  import scr_pkg::*;
#(
  parameter int W = DW,
  parameter int AW = MEM_AW
) (
  input wire logic clk,
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem_q [2**AW];
  logic [W-1:0] rdata_q;

  // single port, write wins
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end else if (re) begin
      rdata_q <= mem_q[addr];
    end
  end

  assign rdata = rdata_q;
endmodule

// ==== scr_fifo.sv ====
`timescale 1ns/1ps
module scr_fifo
  import scr_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  scr_stream_if.snk in_s,
  scr_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] buf_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] wp_d;
  logic [AW:0] rp_q;
  logic [AW:0] rp_d;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = wp_q == rp_q;
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign push = in_s.valid && !full;
  assign pop = out_s.ready && !empty;
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = buf_q[rp_q[AW-1:0]];

  always_comb begin
    wp_d = push ? wp_q + {{AW{1'b0}}, 1'b1} : wp_q;
    rp_d = pop ? rp_q + {{AW{1'b0}}, 1'b1} : rp_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      buf_q[wp_q[AW-1:0]] <= in_s.data;
    end
  end
endmodule

// ==== scr_top.sv ====
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module scr_top
  import scr_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = SCR_CYC_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PAW-1:0] paddr,
  input wire logic [DW-1:0] pwdata,
  output logic [DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_sample_pulse_in,
  input wire logic [DW-1:0] src_magnitude,
  input wire logic [DW-1:0] src_in_phase,
  input wire logic [DW-1:0] src_quadrature,
  input wire logic [DW-1:0] src_phase,
  input wire logic [DW-1:0] aux_input_three,
  input wire logic [DW-1:0] aux_input_four,
  input wire logic [DW-1:0] src_ref_freq,
  output logic capture_running
);
  scr_stream_if #(.W(FIFO_W)) cap_if ();
  scr_stream_if #(.W(FIFO_W)) drn_if ();

  logic [2:0] sy_q;
  logic lvl_q;
  logic lvl_d;
  logic ext_pulse;
  logic acc;
  logic wr_en;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [DW-1:0] prdata_q;
  logic [DW-1:0] prdata_d;
  logic trig_ext_q;
  logic trig_ext_d;
  logic loop_q;
  logic loop_d;
  logic [STEP_W-1:0] step_q;
  logic [STEP_W-1:0] step_d;
  logic [LEN_W-1:0] len_q;
  logic [LEN_W-1:0] len_d;
  logic [ASSIGN_N-1:0][SEL_FW-1:0] sel_q;
  logic [ASSIGN_N-1:0][SEL_FW-1:0] sel_d;
  logic [ASSIGN_N-1:0][SEL_FW-1:0] sel_act_q;
  logic [ASSIGN_N-1:0][SEL_FW-1:0] sel_act_d;
  logic [MEM_AW-1:0] raddr_q;
  logic [MEM_AW-1:0] raddr_d;
  logic rd_req_q;
  logic rd_req_d;
  logic cmd_start;
  logic cmd_pause;
  logic cmd_reset;
  logic cmd_any;
  scr_state_t st_q;
  scr_state_t st_d;
  logic run_q;
  logic [LEN_W-1:0] pt_q;
  logic [LEN_W-1:0] pt_d;
  logic [31:0] cyc_q;
  logic [31:0] cyc_d;
  logic [STEP_W-1:0] ms_q;
  logic [STEP_W-1:0] ms_d;
  logic tick;
  logic trig;
  logic [ASSIGN_N-1:0][DW-1:0] smp_q;
  logic [ASSIGN_N-1:0][DW-1:0] smp_d;
  logic [1:0] widx_q;
  logic [1:0] widx_d;
  logic busy_q;
  logic busy_d;
  logic [BUF_AW-1:0] wpt_q;
  logic [BUF_AW-1:0] wpt_d;
  logic [DW-1:0] mem_rdata;
  logic mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [SRC_N-1:0][DW-1:0] src_all;

  // source mux for one capture store
  function automatic logic [DW-1:0] pick(input logic [SRC_N-1:0][DW-1:0] v, input logic [SEL_FW-1:0] c);
    pick = '0;
    if (c < SEL_FW'(SRC_N)) begin
      pick = v[c[2:0]];
    end
  endfunction

  assign src_all[SRC_MAG] = src_magnitude;
  assign src_all[SRC_INPH] = src_in_phase;
  assign src_all[SRC_QUAD] = src_quadrature;
  assign src_all[SRC_PHASE] = src_phase;
  assign src_all[SRC_AUX3] = aux_input_three;
  assign src_all[SRC_AUX4] = aux_input_four;
  assign src_all[SRC_FREQ] = src_ref_freq;

  // pulse input sync and filter
  assign ext_pulse = (sy_q[1] == sy_q[2]) && sy_q[2] && !lvl_q; // R9
  always_comb begin
    lvl_d = (sy_q[1] == sy_q[2]) ? sy_q[2] : lvl_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy_q <= '0;
      lvl_q <= 1'b0;
    end else begin
      sy_q <= {sy_q[1:0], external_sample_pulse_in};
      lvl_q <= lvl_d;
    end
  end

  // apb slave, one wait state
  assign acc = psel && penable;
  assign wr_en = acc && pready_q && pwrite;
  assign cmd_start = wr_en && (paddr == A_CTRL) && pwdata[CTL_START]; // R11
  assign cmd_pause = wr_en && (paddr == A_CTRL) && pwdata[CTL_PAUSE]; // R11
  assign cmd_reset = wr_en && (paddr == A_CTRL) && pwdata[CTL_RESET]; // R11
  assign cmd_any = cmd_start || cmd_pause || cmd_reset;

  always_comb begin
    pready_d = acc && !pready_q;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    trig_ext_d = trig_ext_q;
    loop_d = loop_q;
    step_d = step_q;
    len_d = len_q;
    sel_d = sel_q;
    raddr_d = raddr_q;
    rd_req_d = 1'b0;
    if (acc && !pready_q) begin
      prdata_d = '0;
      pslverr_d = 1'b0;
      case (paddr)
        A_CTRL: begin
          prdata_d[CTL_EXT] = trig_ext_q;
          prdata_d[CTL_LOOP] = loop_q;
        end
        A_STEP: prdata_d[STEP_W-1:0] = step_q;
        A_LEN: prdata_d[LEN_W-1:0] = len_q;
        A_SEL: prdata_d[ASSIGN_N*SEL_FW-1:0] = sel_q;
        A_STAT: begin
          prdata_d[STAT_ST_LSB +: ST_W] = st_q;
          prdata_d[STAT_BUSY] = busy_q;
          prdata_d[STAT_PT_LSB +: LEN_W] = pt_q; // R14
        end
        A_RADDR: prdata_d[MEM_AW-1:0] = raddr_q;
        A_RDATA: prdata_d = mem_rdata;
        default: pslverr_d = 1'b1;
      endcase
    end
    if (wr_en) begin
      case (paddr)
        A_CTRL: begin
          trig_ext_d = pwdata[CTL_EXT]; // R8
          loop_d = pwdata[CTL_LOOP];
        end
        A_STEP: step_d = STEP_W'(scr_clamp(pwdata, 32'(STEP_MIN_MS), 32'(STEP_MAX_MS))); // R1
        A_LEN: len_d = LEN_W'(scr_clamp(pwdata, 32'(LEN_MIN), 32'(LEN_MAX))); // R2
        A_SEL: sel_d = pwdata[ASSIGN_N*SEL_FW-1:0];
        A_RADDR: begin
          raddr_d = pwdata[MEM_AW-1:0];
          rd_req_d = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
      trig_ext_q <= 1'b0;
      loop_q <= 1'b0;
      step_q <= STEP_RST;
      len_q <= LEN_MAX;
      sel_q <= SEL_RST;
      raddr_q <= '0;
      rd_req_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      trig_ext_q <= trig_ext_d;
      loop_q <= loop_d;
      step_q <= step_d;
      len_q <= len_d;
      sel_q <= sel_d;
      raddr_q <= raddr_d;
      rd_req_q <= rd_req_d;
    end
  end

  // capture sequencer
  always_comb begin
    st_d = st_q;
    pt_d = pt_q;
    cyc_d = cyc_q;
    ms_d = ms_q;
    sel_act_d = sel_act_q;
    smp_d = smp_q;
    widx_d = widx_q;
    busy_d = busy_q;
    wpt_d = wpt_q;
    tick = 1'b0;
    if (st_q == ST_RUN) begin
      if (cyc_q >= 32'(CYC_PER_MS - 1)) begin
        cyc_d = '0;
        if (ms_q + STEP_W'(1) >= step_q) begin
          ms_d = '0;
          tick = 1'b1; // R1
        end else begin
          ms_d = ms_q + STEP_W'(1);
        end
      end else begin
        cyc_d = cyc_q + 32'h1;
      end
    end
    trig = trig_ext_q ? ext_pulse : tick; // R8
    if (busy_q && cap_if.ready) begin
      widx_d = widx_q + 2'h1;
      if (widx_q == 2'(ASSIGN_N - 1)) begin
        busy_d = 1'b0;
      end
    end
    if (st_q == ST_RUN) begin // R16
      if (pt_q >= len_q) begin // R2
        if (loop_q) begin
          pt_d = '0; // R4 R13
        end else begin
          st_d = ST_DONE; // R3 R12
        end
      end else if (trig && !busy_q) begin // R10
        for (int i = 0; i < ASSIGN_N; i++) begin
          smp_d[i] = pick(src_all, sel_act_q[i]); // R6
        end
        busy_d = 1'b1; // R9
        widx_d = '0;
        wpt_d = pt_q[BUF_AW-1:0];
        pt_d = pt_q + LEN_W'(1);
      end
    end
    if (cmd_reset) begin
      st_d = ST_IDLE; // R15
      pt_d = '0;
      cyc_d = '0;
      ms_d = '0;
    end else if (cmd_pause) begin
      if (st_q == ST_RUN) begin
        st_d = ST_PAUSE; // R15
      end
    end else if (cmd_start) begin
      if (st_q == ST_PAUSE) begin
        st_d = ST_RUN; // R15
      end else if (st_q != ST_RUN) begin
        st_d = ST_RUN;
        pt_d = '0;
        cyc_d = '0;
        ms_d = '0;
        sel_act_d = sel_q; // R7
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      run_q <= 1'b0;
      pt_q <= '0;
      cyc_q <= '0;
      ms_q <= '0;
      sel_act_q <= SEL_RST;
      smp_q <= '0;
      widx_q <= '0;
      busy_q <= 1'b0;
      wpt_q <= '0;
    end else begin
      st_q <= st_d;
      run_q <= st_d == ST_RUN;
      pt_q <= pt_d;
      cyc_q <= cyc_d;
      ms_q <= ms_d;
      sel_act_q <= sel_act_d;
      smp_q <= smp_d;
      widx_q <= widx_d;
      busy_q <= busy_d;
      wpt_q <= wpt_d;
    end
  end

  // store path: fifo then memory
  assign cap_if.valid = busy_q;
  assign cap_if.data = {BIDX_W'(widx_q), wpt_q, smp_q[widx_q]}; // R5
  assign drn_if.ready = !rd_req_q;
  assign mem_we = drn_if.valid && !rd_req_q;
  assign mem_addr = rd_req_q ? raddr_q : drn_if.data[FIFO_W-1 -: MEM_AW];

  scr_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_s(cap_if),
    .out_s(drn_if)
  );

  scr_store_mem #(.W(DW), .AW(MEM_AW)) u_mem (
    .clk(pclk),
    .we(mem_we),
    .re(rd_req_q),
    .addr(mem_addr),
    .wdata(drn_if.data[DW-1:0]),
    .rdata(mem_rdata)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign capture_running = run_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_go;
    st_q == ST_RUN && !cmd_any;
  endsequence
  sequence s_held;
    st_q == ST_PAUSE && $stable(pt_q);
  endsequence

  property p_int_capt;
    s_go ##0 (!trig_ext_q && tick && !busy_q && pt_q < len_q) |=> busy_q && pt_q == $past(pt_q) + 1'b1;
  endproperty
  a_int_capt: assert property (p_int_capt) else $error("internal tick missed a point"); // R1
  property p_len_cap;
    pt_q <= LEN_MAX;
  endproperty
  a_len_cap: assert property (p_len_cap) else $error("point count above limit"); // R2
  property p_single_stop;
    s_go ##0 (!loop_q && pt_q >= len_q) |=> st_q == ST_DONE;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single run did not stop"); // R3
  property p_loop_wrap;
    s_go ##0 (loop_q && pt_q >= len_q) |=> st_q == ST_RUN && pt_q == '0;
  endproperty
  a_loop_wrap: assert property (p_loop_wrap) else $error("loop run did not wrap"); // R4
  property p_store_idx;
    mem_we |-> mem_addr[MEM_AW-1 -: BIDX_W] < BIDX_W'(ASSIGN_N);
  endproperty
  a_store_idx: assert property (p_store_idx) else $error("write to unassigned store"); // R5
  property p_src;
    s_go ##0 (trig && !busy_q && pt_q < len_q) |=> smp_q[0] == pick($past(src_all), $past(sel_act_q[0]));
  endproperty
  a_src: assert property (p_src) else $error("wrong source captured"); // R6
  property p_sel_hold;
    (st_q == ST_RUN || st_q == ST_PAUSE) |=> $stable(sel_act_q);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selection changed mid run"); // R7
  property p_ext_only;
    s_go ##0 (trig_ext_q && !ext_pulse) |=> !$rose(busy_q);
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("capture without pulse"); // R8
  property p_ext_capt;
    s_go ##0 (trig_ext_q && ext_pulse && !busy_q && pt_q < len_q) |=> busy_q && pt_q == $past(pt_q) + 1'b1;
  endproperty
  a_ext_capt: assert property (p_ext_capt) else $error("pulse missed a point"); // R9
  property p_reset_cmd;
    cmd_reset |=> st_q == ST_IDLE && pt_q == '0;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command ignored"); // R11
  property p_pause;
    (cmd_pause && !cmd_reset && st_q == ST_RUN) ##1 !cmd_any |=> s_held;
  endproperty
  a_pause: assert property (p_pause) else $error("pause did not hold count"); // R15
  property p_idle_zero;
    st_q == ST_IDLE |-> pt_q == '0;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle point index not zero"); // R14
  property p_no_adv;
    (st_q != ST_RUN && !cmd_any) |=> $stable(pt_q) && !$rose(busy_q);
  endproperty
  a_no_adv: assert property (p_no_adv) else $error("count moved while not running"); // R16
endmodule

// ==== scr_pulse_src.sv ====
`timescale 1ns/1ps
module scr_pulse_src #(
  parameter int GAP = 12,
  parameter int WID = 4
) (
  input wire logic clk,
  input wire logic fire,
  output logic idle,
  output logic pulse
);
  int cnt = 0;
  // pin rests low between pulses
  assign idle = (cnt == 0);
  assign pulse = (cnt > GAP - WID);
  // spacing never shorter than gap, gap at least 2 ms of scaled time
  always @(posedge clk) begin
    if (fire && cnt == 0) begin
      cnt <= GAP;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ==== sample_capture_recorder_tb_top.sv ====
`timescale 1ns/1ps
module sample_capture_recorder_tb_top;
  import scr_pkg::*;
  localparam int CPM = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic capture_running, ext_fire, pulse_line, src_idle;
  logic [PAW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, rd;
  logic [DW-1:0] src_v [SRC_N];
  logic [15:0] sel_w;
  logic [14:0] p1;
  int n_mismatch = 0;
  int cmp_count = 0;
  int run_cyc = 0;

  scr_top #(.CYC_PER_MS(CPM)) i_scr_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_sample_pulse_in(pulse_line), .src_magnitude(src_v[0]), .src_in_phase(src_v[1]),
    .src_quadrature(src_v[2]), .src_phase(src_v[3]), .aux_input_three(src_v[4]),
    .aux_input_four(src_v[5]), .src_ref_freq(src_v[6]), .capture_running(capture_running));
  scr_pulse_src #(.GAP(12)) i_scr_pulse_src (.clk(pclk), .fire(ext_fire), .idle(src_idle),
    .pulse(pulse_line));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (capture_running === 1'b1) run_cyc <= run_cyc + 1;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      chk("pready wait", 32'h0, 32'h1);
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic wait_state(input logic [3:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, A_STAT, 32'h0);
      n++;
    end while (rd[3:0] !== s && n < 2000);
    if (n >= 2000) begin
      chk("state wait", 32'h0, 32'h1);
      report_and_stop();
    end
  endtask

  function automatic logic [31:0] exp_src(input logic [3:0] c);
    return (c < 4'h7) ? src_v[c] : 32'h0;
  endfunction

  task automatic set_src();
    for (int i = 0; i < SRC_N; i++) src_v[i] <= $urandom;
  endtask

  task automatic check_store(input int pts);
    for (int i = 0; i < ASSIGN_N; i++) begin
      for (int p = 0; p < pts; p++) begin
        apb(1'b1, A_RADDR, {15'h0, i[2:0], p[13:0]});
        apb(1'b0, A_RDATA, 32'h0);
        chk("store word", rd, exp_src(sel_w[4*i+:4]));
      end
    end
  endtask

  task automatic pulse_once();
    @(posedge pclk);
    chk("source idle", src_idle, 32'h1);
    ext_fire <= 1'b1;
    @(posedge pclk);
    ext_fire <= 1'b0;
    repeat (24) @(posedge pclk);
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    chk("run time", 32'h0, 32'h1);
    report_and_stop();
  end

  initial begin
    {psel, penable, pwrite, ext_fire, presetn} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    for (int i = 0; i < SRC_N; i++) src_v[i] = 32'h0;
    void'($urandom(74173));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("stat", A_STAT, 32'h1);
    rd_chk("ctrl", A_CTRL, 32'h0);
    rd_chk("step", A_STEP, STEP_RST);
    rd_chk("len", A_LEN, LEN_MAX);
    rd_chk("sel", A_SEL, SEL_RST);
    apb(1'b0, 8'h1c, 32'h0);
    chk("slverr", err, 32'h1);
    apb(1'b1, A_STEP, 32'h0);
    rd_chk("step min", A_STEP, STEP_MIN_MS);
    apb(1'b1, A_STEP, 32'h1ffff);
    rd_chk("step max", A_STEP, STEP_MAX_MS);
    apb(1'b1, A_LEN, 32'h0);
    rd_chk("len min", A_LEN, LEN_MIN);
    apb(1'b1, A_LEN, 32'h7fff);
    rd_chk("len max", A_LEN, LEN_MAX);
    // internal single run, selection changed mid-run
    set_src();
    sel_w = 16'h6543;
    apb(1'b1, A_STEP, 32'h2);
    apb(1'b1, A_LEN, 32'h5);
    apb(1'b1, A_SEL, {16'h0, sel_w});
    apb(1'b1, A_CTRL, 32'h10);
    apb(1'b1, A_SEL, 32'h9210);
    wait_state(ST_DONE);
    chk("point", rd[30:16], 32'h5);
    chk("run cycles", (run_cyc >= 38 && run_cyc <= 46), 32'h1);
    check_store(5);
    // loop run with pause, resume, shrink and reset
    apb(1'b1, A_STEP, 32'h1);
    apb(1'b1, A_LEN, 32'h4000);
    apb(1'b1, A_CTRL, 32'h12);
    repeat (40) @(posedge pclk);
    apb(1'b1, A_CTRL, 32'h22);
    apb(1'b0, A_STAT, 32'h0);
    p1 = rd[30:16];
    chk("paused", rd[3:0], ST_PAUSE);
    repeat (40) @(posedge pclk);
    rd_chk("pause hold", A_STAT, {1'b0, p1, 12'h0, ST_PAUSE});
    apb(1'b1, A_CTRL, 32'h12);
    repeat (40) @(posedge pclk);
    apb(1'b0, A_STAT, 32'h0);
    chk("resumed", (rd[30:16] > p1 && rd[3:0] === ST_RUN), 32'h1);
    apb(1'b1, A_LEN, 32'h2);
    apb(1'b0, A_STAT, 32'h0);
    chk("loop shrink", (rd[30:16] <= 2 && rd[3:0] === ST_RUN), 32'h1);
    repeat (60) @(posedge pclk);
    apb(1'b0, A_STAT, 32'h0);
    chk("loop wrap", (rd[30:16] <= 2 && rd[3:0] === ST_RUN), 32'h1);
    apb(1'b1, A_CTRL, 32'h40);
    // a point taken on the reset edge still drains its store writes
    repeat (8) @(posedge pclk);
    rd_chk("reset", A_STAT, 32'h1);
    // single run cut short by a shorter length
    apb(1'b1, A_LEN, 32'h4000);
    apb(1'b1, A_CTRL, 32'h10);
    repeat (60) @(posedge pclk);
    apb(1'b1, A_LEN, 32'h2);
    apb(1'b0, A_STAT, 32'h0);
    chk("single shrink", rd[3:0], ST_DONE);
    // external pulses
    set_src();
    sel_w = 16'h9210;
    apb(1'b1, A_SEL, {16'h0, sel_w});
    apb(1'b1, A_STEP, 32'h186a0);
    apb(1'b1, A_LEN, 32'h3);
    apb(1'b1, A_CTRL, 32'h41);
    pulse_once();
    rd_chk("idle pulse", A_STAT, 32'h1);
    apb(1'b1, A_CTRL, 32'h11);
    for (int k = 1; k <= 3; k++) begin
      pulse_once();
      apb(1'b0, A_STAT, 32'h0);
      chk("ext point", rd[30:16], k);
    end
    chk("ext done", rd[3:0], ST_DONE);
    pulse_once();
    rd_chk("done pulse", A_STAT, {1'b0, 15'h3, 12'h0, ST_DONE});
    check_store(3);
    report_and_stop();
  end
endmodule
